/* common/io_port_pkg.sv */
package io_port_pkg;
	localparam int ADDR_W = 6;
	localparam logic [1:0] PORT_A = 2'h0;
	localparam logic [1:0] PORT_B = 2'h1;
	localparam logic [1:0] PORT_C = 2'h2;
	localparam logic [1:0] PORT_D = 2'h3;
	localparam logic [3:0] KIND_DATA_IN = 4'h0;
	localparam logic [3:0] KIND_DATA_OUT = 4'h1;
	localparam logic [3:0] KIND_DIRECTION = 4'h2;
	localparam logic [3:0] KIND_DRIVE = 4'h3;
	localparam logic [3:0] KIND_CONTROL = 4'h4;
	localparam logic [3:0] KIND_MCELL_OUT = 4'h5;
	localparam logic [3:0] KIND_LOAD_BLOCK = 4'h6;
	localparam logic [3:0] KIND_INPUT_LATCH = 4'h7;
	localparam logic [3:0] KIND_ENABLE = 4'h8;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] ALL_BITS = 8'hff;
	localparam logic [7:0] PORT_D_BITS = 8'h06;
	localparam logic [7:0] PORT_C_MCELL_BITS = 8'h9c;
	localparam logic [7:0] SLEW_AB = 8'h0f;
	localparam logic [7:0] OPEN_DRAIN_AB = 8'hf0;
	localparam logic [7:0] OPEN_DRAIN_C = 8'hff;
	localparam logic [7:0] SLEW_D = 8'h06;
	localparam logic [7:0] NO_BITS = 8'h00;
endpackage : io_port_pkg

/* rtl/input_macrocell_bank.sv */
`timescale 1ns/1ps
module input_macrocell_bank #(
	parameter logic [7:0] VALID = 8'hff
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ce,
	// capture
	input wire logic latch_en,
	input wire logic [7:0] pins,
	// latched value to array and readback
	output logic [7:0] q_r
);
	logic [7:0] q_nxt;
	always_comb begin
		q_nxt = q_r;
		if (latch_en) begin
			q_nxt = pins & VALID;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			q_r <= io_port_pkg::RESET_BYTE;
		end else if (ce) begin
			q_r <= q_nxt;
		end
	end
endmodule : input_macrocell_bank

/* rtl/io_pin_slice.sv */
`timescale 1ns/1ps
module io_pin_slice #(
	parameter logic [7:0] VALID = 8'hff,
	parameter logic [7:0] SLEW_MASK = 8'h00,
	parameter logic [7:0] OD_MASK = 8'h00
) (
	// configuration and data
	input wire logic [7:0] dir,
	input wire logic [7:0] oe_term,
	input wire logic [7:0] out_val,
	input wire logic [7:0] drive,
	// resolved pin controls
	output logic [7:0] oe_eff,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe,
	output logic [7:0] slew_fast
);
	logic [7:0] od;
	assign od = drive & OD_MASK;
	assign oe_eff = (dir | oe_term) & VALID;
	assign pin_o = out_val & ~od & VALID;
	assign pin_oe = oe_eff & ~(od & out_val);
	assign slew_fast = drive & SLEW_MASK & VALID;
endmodule : io_pin_slice

/* rtl/io_port_data_path.sv */
`timescale 1ns/1ps
module io_port_data_path (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ce,
	// processor register access
	input wire logic bus_sel,
	input wire logic [5:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata_r,
	// processor address latch
	input wire logic addr_strobe,
	input wire logic [7:0] bus_addr_low,
	// logic array terms
	input wire logic [7:0] oe_term_a,
	input wire logic [7:0] oe_term_b,
	input wire logic [7:0] oe_term_c,
	input wire logic [7:0] oe_term_d,
	input wire logic [7:0] array_out_sel_a,
	input wire logic [7:0] array_out_sel_b,
	input wire logic [7:0] array_out_sel_c,
	input wire logic mcell_clk_en,
	input wire logic [7:0] first_macrocell_group_d,
	input wire logic [7:0] second_macrocell_group_d,
	input wire logic first_group_on_b,
	input wire logic second_group_on_c,
	input wire logic input_latch_en,
	input wire logic [1:0] chip_select_term,
	input wire logic [1:0] chip_select_active_high,
	input wire logic [1:0] chip_select_en,
	input wire logic module_select_mode,
	// logic array feeds
	output logic [7:0] first_macrocell_group_r,
	output logic [7:0] second_macrocell_group_r,
	output logic [7:0] input_macrocell_a_r,
	output logic [7:0] input_macrocell_b_r,
	output logic [7:0] input_macrocell_c_r,
	output logic [7:0] array_in_d_r,
	output logic mem_enable_r,
	// pins
	input wire logic [7:0] pin_a_i,
	input wire logic [7:0] pin_b_i,
	input wire logic [7:0] pin_c_i,
	input wire logic [7:0] pin_d_i,
	output logic [7:0] pin_a_o_r,
	output logic [7:0] pin_b_o_r,
	output logic [7:0] pin_c_o_r,
	output logic [7:0] pin_d_o_r,
	output logic [7:0] pin_a_oe_r,
	output logic [7:0] pin_b_oe_r,
	output logic [7:0] pin_c_oe_r,
	output logic [7:0] pin_d_oe_r,
	output logic [7:0] slew_a_r,
	output logic [7:0] slew_b_r,
	output logic [7:0] slew_d_r
);
	logic [3:0][7:0] data_out_r, data_out_nxt;
	logic [3:0][7:0] dir_r, dir_nxt;
	logic [3:0][7:0] drive_r, drive_nxt;
	logic [1:0][7:0] ctrl_r, ctrl_nxt;
	logic [2:0][7:0] mask_r, mask_nxt;
	logic [7:0] addr_latch_r, addr_latch_nxt;
	logic [7:0] first_nxt, second_nxt;
	logic [7:0] rdata_nxt;
	logic mem_enable_nxt;
	logic [3:0][7:0] oe_eff, pin_o, pin_oe, slew, out_val;
	logic [7:0] mc_a, mc_b, mc_c;
	logic [7:0] cs_bits;
	logic [3:0] acc_kind;
	logic [1:0] acc_port;
	logic blocked, wr_ok, rd_ok;

	// register decode inside the control window
	assign acc_kind = bus_addr[5:2];
	assign acc_port = bus_addr[1:0];
	assign blocked = module_select_mode & pin_d_i[2];
	assign wr_ok = bus_sel & bus_wr & ~blocked;
	assign rd_ok = bus_sel & bus_rd & ~blocked;

	function automatic logic [7:0] port_bits(input logic [1:0] p);
		port_bits = (p == io_port_pkg::PORT_D) ? io_port_pkg::PORT_D_BITS : io_port_pkg::ALL_BITS;
	endfunction : port_bits

	// macrocell view per port
	assign mc_a = first_group_on_b ? io_port_pkg::NO_BITS : first_macrocell_group_r;
	assign mc_b = first_group_on_b ? first_macrocell_group_r
		: (second_group_on_c ? io_port_pkg::NO_BITS : second_macrocell_group_r);
	assign mc_c = second_group_on_c ? (second_macrocell_group_r & io_port_pkg::PORT_C_MCELL_BITS)
		: io_port_pkg::NO_BITS;
	assign cs_bits = {5'h00, chip_select_term ~^ chip_select_active_high, 1'b0};

	function automatic logic cs_bits_sel(input int i);
		cs_bits_sel = (i == 1) ? chip_select_en[0] : ((i == 2) ? chip_select_en[1] : 1'b0);
	endfunction : cs_bits_sel

	// pin value selection
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			out_val[0][i] = ctrl_r[0][i] ? addr_latch_r[i]
				: (array_out_sel_a[i] ? mc_a[i] : data_out_r[0][i]);
			out_val[1][i] = ctrl_r[1][i] ? addr_latch_r[i]
				: (array_out_sel_b[i] ? mc_b[i] : data_out_r[1][i]);
			out_val[2][i] = (array_out_sel_c[i] & io_port_pkg::PORT_C_MCELL_BITS[i]) ? mc_c[i]
				: data_out_r[2][i];
			out_val[3][i] = (io_port_pkg::PORT_D_BITS[i] & cs_bits_sel(i)) ? cs_bits[i]
				: data_out_r[3][i];
		end
	end

	io_pin_slice #(.VALID(io_port_pkg::ALL_BITS), .SLEW_MASK(io_port_pkg::SLEW_AB),
		.OD_MASK(io_port_pkg::OPEN_DRAIN_AB)) slice_a (
		.dir(dir_r[0]), .oe_term(oe_term_a), .out_val(out_val[0]), .drive(drive_r[0]),
		.oe_eff(oe_eff[0]), .pin_o(pin_o[0]), .pin_oe(pin_oe[0]), .slew_fast(slew[0]));
	io_pin_slice #(.VALID(io_port_pkg::ALL_BITS), .SLEW_MASK(io_port_pkg::SLEW_AB),
		.OD_MASK(io_port_pkg::OPEN_DRAIN_AB)) slice_b (
		.dir(dir_r[1]), .oe_term(oe_term_b), .out_val(out_val[1]), .drive(drive_r[1]),
		.oe_eff(oe_eff[1]), .pin_o(pin_o[1]), .pin_oe(pin_oe[1]), .slew_fast(slew[1]));
	io_pin_slice #(.VALID(io_port_pkg::ALL_BITS), .SLEW_MASK(io_port_pkg::NO_BITS),
		.OD_MASK(io_port_pkg::OPEN_DRAIN_C)) slice_c (
		.dir(dir_r[2]), .oe_term(oe_term_c), .out_val(out_val[2]), .drive(drive_r[2]),
		.oe_eff(oe_eff[2]), .pin_o(pin_o[2]), .pin_oe(pin_oe[2]), .slew_fast(slew[2]));
	io_pin_slice #(.VALID(io_port_pkg::PORT_D_BITS), .SLEW_MASK(io_port_pkg::SLEW_D),
		.OD_MASK(io_port_pkg::NO_BITS)) slice_d (
		.dir(dir_r[3]), .oe_term(oe_term_d | {5'h00, chip_select_en, 1'b0}), .out_val(out_val[3]),
		.drive(drive_r[3]), .oe_eff(oe_eff[3]), .pin_o(pin_o[3]), .pin_oe(pin_oe[3]), .slew_fast(slew[3]));

	// input macrocells, ports A, B, C only
	input_macrocell_bank #(.VALID(io_port_pkg::ALL_BITS)) imc_a (
		.core_clk(core_clk), .resetn(resetn), .ce(ce), .latch_en(input_latch_en),
		.pins(pin_a_i), .q_r(input_macrocell_a_r));
	input_macrocell_bank #(.VALID(io_port_pkg::ALL_BITS)) imc_b (
		.core_clk(core_clk), .resetn(resetn), .ce(ce), .latch_en(input_latch_en),
		.pins(pin_b_i), .q_r(input_macrocell_b_r));
	input_macrocell_bank #(.VALID(io_port_pkg::PORT_C_MCELL_BITS)) imc_c (
		.core_clk(core_clk), .resetn(resetn), .ce(ce), .latch_en(input_latch_en),
		.pins(pin_c_i), .q_r(input_macrocell_c_r));

	// configuration and data registers
	always_comb begin
		data_out_nxt = data_out_r;
		dir_nxt = dir_r;
		drive_nxt = drive_r;
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		addr_latch_nxt = addr_strobe ? bus_addr_low : addr_latch_r;
		if (wr_ok) begin
			unique case (acc_kind)
				io_port_pkg::KIND_DATA_OUT: data_out_nxt[acc_port] = bus_wdata & port_bits(acc_port);
				io_port_pkg::KIND_DIRECTION: dir_nxt[acc_port] = bus_wdata & port_bits(acc_port);
				io_port_pkg::KIND_DRIVE: drive_nxt[acc_port] = bus_wdata & port_bits(acc_port);
				io_port_pkg::KIND_CONTROL: begin
					if (acc_port == io_port_pkg::PORT_A || acc_port == io_port_pkg::PORT_B) begin
						ctrl_nxt[acc_port[0]] = bus_wdata;
					end
				end
				io_port_pkg::KIND_LOAD_BLOCK: begin
					if (acc_port != io_port_pkg::PORT_D) begin
						mask_nxt[acc_port] = bus_wdata;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			data_out_r <= '0;
			dir_r <= '0;
			drive_r <= '0;
			ctrl_r <= '0;
			mask_r <= '0;
			addr_latch_r <= io_port_pkg::RESET_BYTE;
		end else if (ce) begin
			data_out_r <= data_out_nxt;
			dir_r <= dir_nxt;
			drive_r <= drive_nxt;
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			addr_latch_r <= addr_latch_nxt;
		end
	end

	// output macrocell flops: array clock, processor load unless blocked
	always_comb begin
		first_nxt = mcell_clk_en ? first_macrocell_group_d : first_macrocell_group_r;
		second_nxt = mcell_clk_en ? second_macrocell_group_d : second_macrocell_group_r;
		if (wr_ok && acc_kind == io_port_pkg::KIND_MCELL_OUT) begin
			if (acc_port == io_port_pkg::PORT_A && !first_group_on_b) begin
				first_nxt = (first_nxt & mask_r[0]) | (bus_wdata & ~mask_r[0]);
			end
			if (acc_port == io_port_pkg::PORT_B && first_group_on_b) begin
				first_nxt = (first_nxt & mask_r[1]) | (bus_wdata & ~mask_r[1]);
			end
			if (acc_port == io_port_pkg::PORT_B && !first_group_on_b && !second_group_on_c) begin
				second_nxt = (second_nxt & mask_r[1]) | (bus_wdata & ~mask_r[1]);
			end
			if (acc_port == io_port_pkg::PORT_C && second_group_on_c) begin
				second_nxt = (second_nxt & ~(~mask_r[2] & io_port_pkg::PORT_C_MCELL_BITS))
					| (bus_wdata & ~mask_r[2] & io_port_pkg::PORT_C_MCELL_BITS);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			first_macrocell_group_r <= io_port_pkg::RESET_BYTE;
			second_macrocell_group_r <= io_port_pkg::RESET_BYTE;
		end else if (ce) begin
			first_macrocell_group_r <= first_nxt;
			second_macrocell_group_r <= second_nxt;
		end
	end

	// read data and pin outputs
	always_comb begin
		rdata_nxt = io_port_pkg::RESET_BYTE;
		mem_enable_nxt = ~blocked;
		if (rd_ok) begin
			unique case (acc_kind)
				io_port_pkg::KIND_DATA_IN: begin
					unique case (acc_port)
						io_port_pkg::PORT_A: rdata_nxt = pin_a_i;
						io_port_pkg::PORT_B: rdata_nxt = pin_b_i;
						io_port_pkg::PORT_C: rdata_nxt = pin_c_i;
						io_port_pkg::PORT_D: rdata_nxt = pin_d_i & io_port_pkg::PORT_D_BITS;
					endcase
				end
				io_port_pkg::KIND_DATA_OUT: rdata_nxt = data_out_r[acc_port];
				io_port_pkg::KIND_DIRECTION: rdata_nxt = dir_r[acc_port];
				io_port_pkg::KIND_DRIVE: rdata_nxt = drive_r[acc_port];
				io_port_pkg::KIND_CONTROL: rdata_nxt = acc_port[1] ? io_port_pkg::NO_BITS : ctrl_r[acc_port[0]];
				io_port_pkg::KIND_MCELL_OUT: begin
					unique case (acc_port)
						io_port_pkg::PORT_A: rdata_nxt = mc_a;
						io_port_pkg::PORT_B: rdata_nxt = mc_b;
						io_port_pkg::PORT_C: rdata_nxt = mc_c;
						io_port_pkg::PORT_D: rdata_nxt = io_port_pkg::NO_BITS;
					endcase
				end
				io_port_pkg::KIND_LOAD_BLOCK: rdata_nxt = (acc_port == io_port_pkg::PORT_D) ? io_port_pkg::NO_BITS
					: mask_r[acc_port];
				io_port_pkg::KIND_INPUT_LATCH: begin
					unique case (acc_port)
						io_port_pkg::PORT_A: rdata_nxt = input_macrocell_a_r;
						io_port_pkg::PORT_B: rdata_nxt = input_macrocell_b_r;
						io_port_pkg::PORT_C: rdata_nxt = input_macrocell_c_r;
						io_port_pkg::PORT_D: rdata_nxt = io_port_pkg::NO_BITS;
					endcase
				end
				io_port_pkg::KIND_ENABLE: rdata_nxt = (acc_port == io_port_pkg::PORT_D) ? io_port_pkg::NO_BITS
					: oe_eff[acc_port];
				default: rdata_nxt = io_port_pkg::NO_BITS;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			bus_rdata_r <= io_port_pkg::RESET_BYTE;
			mem_enable_r <= 1'b1;
			array_in_d_r <= io_port_pkg::RESET_BYTE;
			{pin_a_o_r, pin_b_o_r, pin_c_o_r, pin_d_o_r} <= '0;
			{pin_a_oe_r, pin_b_oe_r, pin_c_oe_r, pin_d_oe_r} <= '0;
			{slew_a_r, slew_b_r, slew_d_r} <= '0;
		end else if (ce) begin
			bus_rdata_r <= rdata_nxt;
			mem_enable_r <= mem_enable_nxt;
			array_in_d_r <= pin_d_i & io_port_pkg::PORT_D_BITS;
			pin_a_o_r <= pin_o[0];
			pin_b_o_r <= pin_o[1];
			pin_c_o_r <= pin_o[2];
			pin_d_o_r <= pin_o[3];
			pin_a_oe_r <= pin_oe[0];
			pin_b_oe_r <= pin_oe[1];
			pin_c_oe_r <= pin_oe[2];
			pin_d_oe_r <= pin_oe[3];
			slew_a_r <= slew[0];
			slew_b_r <= slew[1];
			slew_d_r <= slew[3];
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	AST_OE_RESOLVE: assert property ((ce && drive_r[0] == 8'h00) |=> pin_a_oe_r == $past(dir_r[0] | oe_term_a))
		else $error("port A enable not direction or term");
	AST_PIN_READ: assert property ((ce && rd_ok && acc_kind == io_port_pkg::KIND_DATA_IN
		&& acc_port == io_port_pkg::PORT_B) |=> bus_rdata_r == $past(pin_b_i))
		else $error("pin read not live level");
	AST_DATA_OUT: assert property ((ce && wr_ok && acc_kind == io_port_pkg::KIND_DATA_OUT
		&& acc_port == io_port_pkg::PORT_C) |=> data_out_r[2] == $past(bus_wdata))
		else $error("output latch write lost");
	AST_LOAD_BLOCK: assert property ((ce && wr_ok && !mcell_clk_en && !first_group_on_b
		&& acc_kind == io_port_pkg::KIND_MCELL_OUT && acc_port == io_port_pkg::PORT_A)
		|=> (first_macrocell_group_r & $past(mask_r[0])) == ($past(first_macrocell_group_r) & $past(mask_r[0])))
		else $error("blocked macrocell bit loaded");
	AST_RESET_ZERO: assert property ($rose(resetn) |-> dir_r == '0 && ctrl_r == '0 && drive_r == '0 && mask_r == '0)
		else $error("configuration not cleared by reset");
	AST_ENABLE_READ: assert property ((ce && rd_ok && acc_kind == io_port_pkg::KIND_ENABLE
		&& acc_port == io_port_pkg::PORT_A) |=> bus_rdata_r == $past(dir_r[0] | oe_term_a))
		else $error("enable status wrong");
	AST_PORT_D_BITS: assert property (((data_out_r[3] | dir_r[3] | drive_r[3])
		& ~io_port_pkg::PORT_D_BITS) == 8'h00)
		else $error("port D unused bit set");
	AST_PORT_C_INPUTS: assert property ((input_macrocell_c_r & ~io_port_pkg::PORT_C_MCELL_BITS) == 8'h00)
		else $error("port C reserved input latched");
	AST_BLOCKED: assert property ((ce && blocked && bus_sel && bus_wr) |=> $stable(data_out_r) && $stable(dir_r))
		else $error("access taken while deselected");
	AST_ADDR_OUT: assert property ((ce && ctrl_r[1] == 8'hff && drive_r[1] == 8'h00)
		|=> pin_b_o_r == $past(addr_latch_r))
		else $error("address byte not on port B");
	AST_CHIP_SEL: assert property ((ce && chip_select_en[0] && dir_r[3] == 8'h00)
		|=> pin_d_oe_r[1] && pin_d_o_r[1] == $past(chip_select_term[0] ~^ chip_select_active_high[0]))
		else $error("chip select polarity wrong");
endmodule : io_port_data_path

/* tb/io_pin_partner.sv */
`timescale 1ns/1ps
module io_pin_partner (
	// design drive
	input wire logic [31:0] drv_o,
	input wire logic [31:0] drv_oe,
	// external drivers
	input wire logic [31:0] ext_val,
	input wire logic [31:0] ext_en,
	// resolved pin levels
	output logic [31:0] lvl
);
	// design wins, then external driver, else pull-up
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			lvl[i] = drv_oe[i] ? drv_o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule : io_pin_partner

/* tb/io_port_data_path_bench.sv */
`timescale 1ns/1ps
module io_port_data_path_bench;
	logic core_clk = 1'b0, resetn = 1'b0, bus_sel = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, addr_strobe = 1'b0;
	logic mcell_clk_en = 1'b0, first_group_on_b = 1'b0, input_latch_en = 1'b0, module_select_mode = 1'b0;
	logic second_group_on_c = 1'b0;
	logic [5:0] bus_addr = 6'h00;
	logic [7:0] bus_wdata = 8'h00, bus_addr_low = 8'h00, fg_d = 8'h00, sg_d = 8'h00;
	logic [1:0] cs_term = 2'h0, cs_high = 2'h0, cs_en = 2'h0;
	logic [31:0] ext_val = 32'h0, ext_en = 32'h0, rng = 32'h2f;
	logic [7:0] term [4] = '{default: 8'h00};
	logic [7:0] dout [4] = '{default: 8'h00}, dir [4] = '{default: 8'h00}, drv [4] = '{default: 8'h00};
	logic [7:0] ctl [4] = '{default: 8'h00}, ilat [4] = '{default: 8'h00}, lv [4] = '{default: 8'hff};
	logic [7:0] bus_rdata_r, fg_r, sg_r, ima, imb, input_macrocell, aid, sla, slb, sld, rdv, r, msk, en, od, val, eoe, r1, r2, m, v;
	logic mem_enable_r;
	wire [31:0] o_all, oe_all, lvl;
	int fails, num_checks, cyc;

	io_port_data_path DUT (
		.core_clk(core_clk), .resetn(resetn), .ce(1'b1), .bus_sel(bus_sel), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_r(bus_rdata_r), .addr_strobe(addr_strobe),
		.bus_addr_low(bus_addr_low), .oe_term_a(term[0]), .oe_term_b(term[1]), .oe_term_c(term[2]), .oe_term_d(term[3]),
		.array_out_sel_a(8'h00), .array_out_sel_b(8'h00), .array_out_sel_c(8'h00), .mcell_clk_en(mcell_clk_en),
		.first_macrocell_group_d(fg_d), .second_macrocell_group_d(sg_d), .first_group_on_b(first_group_on_b),
		.second_group_on_c(second_group_on_c), .input_latch_en(input_latch_en), .chip_select_term(cs_term),
		.chip_select_active_high(cs_high), .chip_select_en(cs_en), .module_select_mode(module_select_mode),
		.first_macrocell_group_r(fg_r), .second_macrocell_group_r(sg_r), .input_macrocell_a_r(ima),
		.input_macrocell_b_r(imb), .input_macrocell_c_r(input_macrocell), .array_in_d_r(aid), .mem_enable_r(mem_enable_r),
		.pin_a_i(lvl[7:0]), .pin_b_i(lvl[15:8]), .pin_c_i(lvl[23:16]), .pin_d_i(lvl[31:24]),
		.pin_a_o_r(o_all[7:0]), .pin_b_o_r(o_all[15:8]), .pin_c_o_r(o_all[23:16]), .pin_d_o_r(o_all[31:24]),
		.pin_a_oe_r(oe_all[7:0]), .pin_b_oe_r(oe_all[15:8]), .pin_c_oe_r(oe_all[23:16]), .pin_d_oe_r(oe_all[31:24]),
		.slew_a_r(sla), .slew_b_r(slb), .slew_d_r(sld)
	);

	io_pin_partner partner (.drv_o(o_all), .drv_oe(oe_all), .ext_val(ext_val), .ext_en(ext_en), .lvl(lvl));

	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	function automatic logic [7:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction : rnd

	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask : settle

	task automatic wr(input logic [3:0] k, input int p, input logic [7:0] d);
		bus_sel = 1'b1;
		bus_wr = 1'b1;
		bus_addr = {k, 2'(p)};
		bus_wdata = d;
		@(posedge core_clk);
		#1;
		bus_wr = 1'b0;
		bus_sel = 1'b0;
		addr_strobe = 1'b0;
		@(posedge core_clk);
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] k, input int p, output logic [7:0] d);
		bus_sel = 1'b1;
		bus_rd = 1'b1;
		bus_addr = {k, 2'(p)};
		@(posedge core_clk);
		#1;
		bus_rd = 1'b0;
		bus_sel = 1'b0;
		d = bus_rdata_r;
		@(posedge core_clk);
		#1;
	endtask : rd

	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: read %h expected %h", $time, got, exp);
		end
	endtask : chk_rd

	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: port output %h expected %h", $time, got, exp);
		end
	endtask : chk_pin

	task automatic rdc(input logic [3:0] k, input int p, input logic [7:0] e);
		logic [7:0] d;
		rd(k, p, d);
		chk_rd(d, e);
	endtask : rdc

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 12000) begin
			fails++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (16) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		for (int p = 0; p < 4; p++) begin
			rdc(io_port_pkg::KIND_DIRECTION, p, 8'h00);
			rdc(io_port_pkg::KIND_DRIVE, p, 8'h00);
			rdc(io_port_pkg::KIND_CONTROL, p, 8'h00);
			rdc(io_port_pkg::KIND_LOAD_BLOCK, p, 8'h00);
		end
		// random port setups
		for (int it = 0; it < 6; it++) begin
			for (int p = 0; p < 4; p++) begin
				msk = (p == 3) ? 8'h06 : 8'hff;
				r = rnd();
				input_latch_en = r[0];
				ext_val[8*p +: 8] = rnd();
				ext_en[8*p +: 8] = rnd();
				term[p] = rnd() & msk;
				bus_addr_low = rnd();
				addr_strobe = 1'b1;
				r = rnd();
				wr(io_port_pkg::KIND_DATA_OUT, p, r);
				dout[p] = r & msk;
				r = rnd();
				wr(io_port_pkg::KIND_DIRECTION, p, r);
				dir[p] = r & msk;
				r = rnd();
				wr(io_port_pkg::KIND_DRIVE, p, r);
				drv[p] = r & msk;
				r = rnd();
				wr(io_port_pkg::KIND_CONTROL, p, r);
				ctl[p] = (p < 2) ? r : 8'h00;
				settle();
				// every port level, since the address latch moves ports A and B too
				for (int q = 0; q < 4; q++) begin
					m = (q == 3) ? 8'h06 : 8'hff;
					od = (q < 2) ? (drv[q] & 8'hf0) : ((q == 2) ? drv[q] : 8'h00);
					val = (ctl[q] & bus_addr_low) | (~ctl[q] & dout[q]);
					eoe = (dir[q] | term[q]) & m & ~(od & val);
					lv[q] = (eoe & val) | (~eoe & (~ext_en[8*q +: 8] | ext_val[8*q +: 8]));
					if (q == p) begin
						chk_pin(oe_all[8*q +: 8], eoe);
						chk_pin(o_all[8*q +: 8] & eoe, val & eoe);
					end
				end
				en = (dir[p] | term[p]) & msk;
				for (int q = 0; q < 3; q++)
					if (input_latch_en)
						ilat[q] = lv[q] & ((q == 2) ? 8'h9c : 8'hff);
				rd(io_port_pkg::KIND_DATA_IN, p, rdv);
				chk_rd(rdv & msk, lv[p] & msk);
				rdc(io_port_pkg::KIND_DATA_OUT, p, dout[p]);
				rdc(io_port_pkg::KIND_DIRECTION, p, dir[p]);
				rdc(io_port_pkg::KIND_DRIVE, p, drv[p]);
				rdc(io_port_pkg::KIND_CONTROL, p, ctl[p]);
				rdc(io_port_pkg::KIND_ENABLE, p, (p < 3) ? en : 8'h00);
				rdc(io_port_pkg::KIND_INPUT_LATCH, p, (p < 3) ? ilat[p] : 8'h00);
			end
			chk_pin(sla, drv[0] & 8'h0f);
			chk_pin(slb, drv[1] & 8'h0f);
			chk_pin(sld, drv[3] & 8'h06);
			chk_pin(aid, lv[3] & 8'h06);
			chk_pin(ima, ilat[0]);
			chk_pin(imb, ilat[1]);
			chk_pin(input_macrocell, ilat[2]);
		end
		// macrocell load and mask
		for (int it = 0; it < 3; it++) begin
			r1 = rnd();
			r2 = rnd();
			m = rnd();
			v = rnd();
			fg_d = r1;
			sg_d = r2;
			mcell_clk_en = 1'b1;
			@(posedge core_clk);
			#1;
			mcell_clk_en = 1'b0;
			@(posedge core_clk);
			#1;
			chk_pin(fg_r, r1);
			chk_pin(sg_r, r2);
			rdc(io_port_pkg::KIND_MCELL_OUT, 0, r1);
			rdc(io_port_pkg::KIND_MCELL_OUT, 1, r2);
			wr(io_port_pkg::KIND_LOAD_BLOCK, 0, m);
			wr(io_port_pkg::KIND_MCELL_OUT, 0, v);
			rdc(io_port_pkg::KIND_LOAD_BLOCK, 0, m);
			rdc(io_port_pkg::KIND_MCELL_OUT, 0, (r1 & m) | (v & ~m));
			rdc(io_port_pkg::KIND_MCELL_OUT, 3, 8'h00);
		end
		first_group_on_b = 1'b1;
		rdc(io_port_pkg::KIND_MCELL_OUT, 1, (r1 & m) | (v & ~m));
		second_group_on_c = 1'b1;
		rdc(io_port_pkg::KIND_MCELL_OUT, 2, r2 & 8'h9c);
		wr(io_port_pkg::KIND_MCELL_OUT, 2, v);
		chk_pin(sg_r, (r2 & 8'h63) | (v & 8'h9c));
		rdc(io_port_pkg::KIND_MCELL_OUT, 2, v & 8'h9c);
		// chip select polarity
		wr(io_port_pkg::KIND_DIRECTION, 3, 8'h00);
		term[3] = 8'h00;
		for (int k = 0; k < 4; k++) begin
			cs_en = 2'h3;
			cs_term = {2{k[0]}};
			cs_high = {2{k[1]}};
			settle();
			chk_pin(oe_all[31:24] & 8'h06, 8'h06);
			chk_pin(o_all[31:24] & 8'h06, (k[0] == k[1]) ? 8'h06 : 8'h00);
		end
		cs_en = 2'h0;
		// port B in address out mode
		wr(io_port_pkg::KIND_DRIVE, 1, 8'h00);
		wr(io_port_pkg::KIND_DIRECTION, 1, 8'hff);
		wr(io_port_pkg::KIND_CONTROL, 1, 8'hff);
		settle();
		chk_pin(oe_all[15:8], 8'hff);
		chk_pin(o_all[15:8], bus_addr_low);
		// module select blocks the window
		module_select_mode = 1'b1;
		ext_en[26] = 1'b1;
		ext_val[26] = 1'b1;
		settle();
		chk_pin({7'h00, mem_enable_r}, 8'h00);
		wr(io_port_pkg::KIND_DATA_OUT, 0, ~dout[0]);
		rdc(io_port_pkg::KIND_DATA_OUT, 0, 8'h00);
		ext_val[26] = 1'b0;
		settle();
		chk_pin({7'h00, mem_enable_r}, 8'h01);
		rdc(io_port_pkg::KIND_DATA_OUT, 0, dout[0]);
		rdc(4'h9, 0, 8'h00);
		rdc(4'hf, 2, 8'h00);
		tally_and_finish();
	end
endmodule : io_port_data_path_bench
